// ---- common/pmsa_pkg.sv ----
// Package for the port transceiver status and negotiation register view.
// Assumes one system clock and a word-wide AHB-Lite register bus.
package pmsa_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [3:0] IDX_BASIC_STATUS = 4'h2;
    localparam logic [3:0] IDX_IDENT_LOW = 4'h4;
    localparam logic [3:0] IDX_IDENT_HIGH = 4'h6;
    localparam logic [3:0] IDX_NEG_ADVERT = 4'h8;
    localparam logic [3:0] IDX_PARTNER = 4'hA;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_T4 = 15;
    localparam int BIT_CAP_TOP = 14;
    localparam int BIT_CAP_BOT = 11;
    localparam int BIT_NEG_DONE = 5;
    localparam int BIT_NEG_ABLE = 3;
    localparam int BIT_LINK = 2;
    localparam int BIT_EXTENDED = 0;
    localparam int BIT_PAUSE = 10;
    localparam int BIT_ADV_RSVD = 9;
    localparam int BIT_ABIL_TOP = 8;
    localparam int BIT_ABIL_BOT = 5;
    localparam int SEL_TOP = 4;

    // ****************************************************************
    // Fixed values and reset values
    // ****************************************************************
    localparam logic [3:0] CAP_ALL = 4'hF;
    localparam logic [4:0] SELECTOR_8023 = 5'h01;
    localparam logic [4:0] PARTNER_LOW = 5'h01;
    localparam logic ADV_RSVD_RESET = 1'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    // One set of abilities, as advertised or as heard from the partner.
    typedef struct packed {
        logic pause;
        logic full_100;
        logic half_100;
        logic full_10;
        logic half_10;
    } pmsa_abil_t;

    localparam pmsa_abil_t ADV_RESET = 5'h1F;

    // Status pushed in from the transceiver and negotiation engine.
    typedef struct packed {
        logic negotiation_done;
        logic link_up;
        pmsa_abil_t partner;
    } pmsa_phy_stat_t;

endpackage : pmsa_pkg

// ---- rtl/pmsa_regs.sv ----
// Register view of one switch port transceiver on an AHB-Lite slave.
// Assumes a single master, status inputs from the analog side that are
// asynchronous, and a neighbouring bank that may write the advert bits.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Four speed/duplex capability bits read one
// - T4 capability bit reads zero, ignores writes
// - Status bit five shows negotiation done
// - Status bit three always reads one
// - Extended capability bit reads zero
// - Low identity word is read-only constant
// - High identity word is read-only constant
// - Pause advert bit, writable, resets one, shared
// - 100 full advert bit, writable, resets one
// - 100 half advert bit, writable, resets one
// - 10 full advert bit, writable, resets one
// - 10 half advert bit, writable, resets one
// - Partner pause bit mirrors received status
// - Partner 100 full bit mirrors received status
// - Partner 100 half bit mirrors received status
// - Partner 10 full bit mirrors received status
// - Partner 10 half bit mirrors received status
module pmsa_regs #(
    parameter int ADDR_W = 8,
    // Arbitrary neutral identifier values.
    parameter logic [15:0] IDENT_LOW = 16'hA5A5,
    parameter logic [15:0] IDENT_HIGH = 16'h5A5A
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Status from the transceiver, asynchronous
    input wire pmsa_pkg::pmsa_phy_stat_t phy_stat,
    // Shared advert storage: the other bank's write port
    input wire logic alt_wr_en,
    input wire pmsa_pkg::pmsa_abil_t alt_wr_data,
    // Advertised abilities towards the negotiation engine
    output pmsa_pkg::pmsa_abil_t advert
);
    import pmsa_pkg::*;

    // ****************************************************************
    // Status synchroniser
    // ****************************************************************
    pmsa_phy_stat_t sync1_reg, sync1_next;
    pmsa_phy_stat_t stat_reg, stat_next;

    always_comb begin
        sync1_next = phy_stat;
        stat_next = sync1_reg;
        if (!rst_b) begin
            sync1_next = '0;
            stat_next = '0;
        end
    end

    always_ff @(posedge clock) begin
        sync1_reg <= sync1_next;
        stat_reg <= stat_next;
    end

    // ****************************************************************
    // Bus address phase capture
    // ****************************************************************
    logic wr_pend_reg, wr_pend_next;
    logic [3:0] wr_idx_reg, wr_idx_next;
    logic [31:0] rdata_reg, rdata_next;
    logic adv_rsvd_reg, adv_rsvd_next;
    pmsa_abil_t adv_reg, adv_next;
    logic take;
    logic mapped;
    logic [3:0] idx;
    logic [15:0] word;
    logic [15:0] adv_word;
    logic wr_adv;

    // The upper address bits and the byte lane must both be zero, so
    // aliases never reach a register.
    assign take = hsel && hready && (htrans == HTRANS_NONSEQ ||
                                     htrans == HTRANS_SEQ);
    assign idx = haddr[5:2];
    assign mapped = (haddr[1:0] == 2'h0) &&
                    (haddr[ADDR_W-1:6] == '0);
    assign wr_adv = wr_pend_reg && (wr_idx_reg == IDX_NEG_ADVERT);

    // Advert word as this cycle's bus write data phase will leave it, with a same-cycle
    // bank write not shown, so a read that follows a write back to back sees the new value.
    always_comb begin
        adv_word = '0;
        adv_word[BIT_PAUSE] = wr_adv ? hwdata[BIT_PAUSE] : adv_reg.pause;
        adv_word[BIT_ADV_RSVD] = wr_adv ? hwdata[BIT_ADV_RSVD]
                                        : adv_rsvd_reg;
        adv_word[BIT_ABIL_TOP:BIT_ABIL_BOT] = wr_adv ?
            hwdata[BIT_ABIL_TOP:BIT_ABIL_BOT] :
            {adv_reg.full_100, adv_reg.half_100,
             adv_reg.full_10, adv_reg.half_10};
        adv_word[SEL_TOP:0] = SELECTOR_8023;
    end

    always_comb begin
        word = '0;
        case (idx)
            IDX_BASIC_STATUS: begin
                word[BIT_T4] = 1'b0;
                word[BIT_CAP_TOP:BIT_CAP_BOT] = CAP_ALL;
                word[BIT_NEG_DONE] = stat_reg.negotiation_done;
                word[BIT_NEG_ABLE] = 1'b1;
                word[BIT_LINK] = stat_reg.link_up;
                word[BIT_EXTENDED] = 1'b0;
            end
            IDX_IDENT_LOW: word = IDENT_LOW;
            IDX_IDENT_HIGH: word = IDENT_HIGH;
            IDX_NEG_ADVERT: word = adv_word;
            IDX_PARTNER: begin
                word[BIT_PAUSE] = stat_reg.partner.pause;
                word[8] = stat_reg.partner.full_100;
                word[7] = stat_reg.partner.half_100;
                word[6] = stat_reg.partner.full_10;
                word[5] = stat_reg.partner.half_10;
                word[SEL_TOP:0] = PARTNER_LOW;
            end
            default: word = '0;
        endcase
        if (!mapped) begin
            word = '0;
        end
    end

    always_comb begin
        wr_pend_next = take && hwrite && mapped;
        wr_idx_next = idx;
        rdata_next = rdata_reg;
        if (take && !hwrite) begin
            rdata_next = {16'h0000, word};
        end
        if (!rst_b) begin
            wr_pend_next = 1'b0;
            wr_idx_next = '0;
            rdata_next = '0;
        end
    end

    // ****************************************************************
    // Advert storage shared with the other bank
    // ****************************************************************
    // A bus write wins over the other bank's write in the same cycle;
    // both land in the one storage, so neither view can drift apart.
    always_comb begin
        adv_next = adv_reg;
        adv_rsvd_next = adv_rsvd_reg;
        if (alt_wr_en) begin
            adv_next = alt_wr_data;
        end
        if (wr_adv) begin
            adv_next.pause = hwdata[BIT_PAUSE];
            adv_next.full_100 = hwdata[8];
            adv_next.half_100 = hwdata[7];
            adv_next.full_10 = hwdata[6];
            adv_next.half_10 = hwdata[5];
            adv_rsvd_next = hwdata[BIT_ADV_RSVD];
        end
        if (!rst_b) begin
            adv_next = ADV_RESET;
            adv_rsvd_next = ADV_RSVD_RESET;
        end
    end

    always_ff @(posedge clock) begin
        wr_pend_reg <= wr_pend_next;
        wr_idx_reg <= wr_idx_next;
        rdata_reg <= rdata_next;
        adv_reg <= adv_next;
        adv_rsvd_reg <= adv_rsvd_next;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Every access completes with no wait state and an OKAY answer.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;
    assign advert = adv_reg;

endmodule : pmsa_regs
`default_nettype wire

// ---- test/pmsa_regs_checker.sv ----
// Assertions on the ports of the port transceiver register view.
// Assumes hready is fed back from hreadyout by the surroundings.
`timescale 1ns/1ps
`default_nettype none
module pmsa_regs_checker #(
    parameter int ADDR_W = 8,
    parameter logic [15:0] IDENT_LOW = 16'h0000
) (
    // Bus
    input wire logic clock,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Status and shared advert storage
    input wire pmsa_pkg::pmsa_phy_stat_t phy_stat,
    input wire logic alt_wr_en,
    input wire pmsa_pkg::pmsa_abil_t alt_wr_data,
    input wire pmsa_pkg::pmsa_abil_t advert
);
    import pmsa_pkg::*;
    logic taken;
    logic adv_wr_dp;
    assign taken = hsel && hready && htrans[1];
    // A bus write in its data phase beats a same-cycle write from the bank.
    always_ff @(posedge clock) begin
        adv_wr_dp <= rst_b && taken && hwrite && haddr == ADDR_W'(8'h20);
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence rd_at(logic [3:0] idx);
        taken && !hwrite && haddr == ADDR_W'({idx, 2'h0});
    endsequence
    sequence held_4;
        $stable(phy_stat) [*4];
    endsequence
    reset_advert_a: assert property (
        $rose(rst_b) |-> advert == ADV_RESET)
        else $error("advert not at reset value");
    stat_fixed_a: assert property (
        rd_at(IDX_BASIC_STATUS) |=> (hrdata & 32'hFFFFFFDB) == 32'h00007808)
        else $error("fixed status bits wrong");
    stat_live_a: assert property (
        held_4 ##0 rd_at(IDX_BASIC_STATUS) |=>
        hrdata[5] == $past(phy_stat.negotiation_done) &&
        hrdata[2] == $past(phy_stat.link_up))
        else $error("live status bits wrong");
    ident_low_a: assert property (
        rd_at(IDX_IDENT_LOW) |=> hrdata == {16'h0000, IDENT_LOW})
        else $error("low identity word wrong");
    partner_live_a: assert property (
        held_4 ##0 rd_at(IDX_PARTNER) |=>
        hrdata[10] == $past(phy_stat.partner.pause) &&
        hrdata[8:5] == $past(phy_stat.partner[3:0]))
        else $error("partner ability bits wrong");
    advert_write_a: assert property (
        adv_wr_dp |=> advert == {$past(hwdata[10]), $past(hwdata[8:5])})
        else $error("bus write did not reach advert");
    alt_write_a: assert property (
        alt_wr_en && !adv_wr_dp |=> advert == $past(alt_wr_data))
        else $error("bank write did not reach advert");
    advert_read_a: assert property (
        rd_at(IDX_NEG_ADVERT) ##0 (!alt_wr_en && !adv_wr_dp) |=>
        hrdata[4:0] == SELECTOR_8023 && hrdata[10] == advert.pause &&
        hrdata[8:5] == advert[3:0] && hrdata[31:11] == 21'h0)
        else $error("advert readback wrong");
endmodule : pmsa_regs_checker
bind pmsa_regs pmsa_regs_checker #(.ADDR_W(ADDR_W), .IDENT_LOW(IDENT_LOW))
    chk (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .phy_stat(phy_stat), .alt_wr_en(alt_wr_en),
    .alt_wr_data(alt_wr_data), .advert(advert));
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for pmsa_regs over AHB-Lite.
// Assumes the bench alone drives every input of the design.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pmsa_pkg::*;
    localparam logic [15:0] ID_LO = 16'h3C3C; // Arbitrary value.
    localparam logic [15:0] ID_HI = 16'hC3C3; // Arbitrary value.
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic alt_wr_en = 1'b0;
    logic hready, hresp, rd_dp = 1'b0, b9;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h00000000, hrdata;
    logic [15:0] rnd = 16'h0023;
    logic [31:0] exp_q[$];
    int num_errors = 0, comparisons = 0;
    pmsa_phy_stat_t phy_stat = '0;
    pmsa_abil_t alt_wr_data = '0, advert, adv;
    always #5 clock = ~clock;
    pmsa_regs #(.ADDR_W(8), .IDENT_LOW(ID_LO), .IDENT_HIGH(ID_HI)) dut (
        .clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .phy_stat(phy_stat), .alt_wr_en(alt_wr_en),
        .alt_wr_data(alt_wr_data), .advert(advert));
    task check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            num_errors++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    function logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    function logic [7:0] ba(input logic [3:0] i);
        return {2'h0, i, 2'h0};
    endfunction : ba
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
    endtask : bus
    task rd(input logic [7:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        bus(a, 1'b0, {rnd, rnd});
    endtask : rd
    // Read data stands at the edge that ends the data phase.
    always @(posedge clock) begin
        if (rd_dp) check(hrdata, exp_q.pop_front());
        rd_dp <= hsel && htrans[1] && !hwrite && hready === 1'b1;
    end
    task finish_test;
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        #20000;
        num_errors++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        adv = ADV_RESET;
        b9 = ADV_RSVD_RESET;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 12; i++) begin
            check({27'h0, advert}, {27'h0, adv});
            rd(ba(IDX_BASIC_STATUS), {16'h0, 5'h0F, 5'h0,
                phy_stat.negotiation_done, 2'h1, phy_stat.link_up,
                2'h0});
            rd(ba(IDX_IDENT_LOW), {16'h0, ID_LO});
            rd(ba(IDX_IDENT_HIGH), {16'h0, ID_HI});
            rd(ba(IDX_NEG_ADVERT), {21'h0, adv.pause, b9, adv[3:0],
                5'h01});
            rd(ba(IDX_PARTNER), {21'h0, phy_stat.partner.pause, 1'b0,
                phy_stat.partner[3:0], 5'h01});
            rd(ba(4'h3), 32'h0);
            rnd = lfsr(rnd);
            for (int j = 2; j <= 10; j += 2) bus(ba(j[3:0]), 1'b1, {rnd, rnd});
            adv = {rnd[10], rnd[8:5]};
            b9 = rnd[9];
            phy_stat <= pmsa_phy_stat_t'(rnd[15:9] ^ rnd[6:0]);
            if (i[0]) begin
                alt_wr_en <= 1'b1;
                alt_wr_data <= pmsa_abil_t'(rnd[4:0]);
                @(posedge clock);
                alt_wr_en <= 1'b0;
                adv = pmsa_abil_t'(rnd[4:0]);
            end
            repeat (5) @(posedge clock);
        end
        repeat (3) @(posedge clock);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
